/* File: rtl/tad_detector.sv */
// Transient acceleration event detector with its four registers.
// Assumes one sampleValid pulse per output data sample, samples signed on
// the 8 g scale at threshold resolution, and a register front end that
// issues one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "tad_params.svh"

// Overview of operation
// [R1] Config bit 0 picks raw samples when 1, filtered samples when 0.
// [R2] Config bits 3..1 enable Z, Y, X event flags; cleared disables axis.
// [R3] Config bit 4 latches event flags in source register until read.
// [R4] Reading source register clears all its status bits and the request.
// [R5] Latch on: first event sets axis bits; none clear before read.
// [R6] Latch on and event active set: other source bits hold until read.
// [R7] Source bit 6 is one when any axis event flag is set.
// [R8] Source bits 5, 3, 1 flag Z, Y, X threshold exceedance.
// [R9] Source bits 4, 2, 0 give triggering sign, one for negative.
// [R10] Unsigned sample magnitude must be strictly above the threshold.
// [R11] Qualified condition raises axis flag and request when enabled.
// [R12] Threshold is bits 6..0, on the 8 g scale.
// [R13] Threshold bit 7 picks decrement mode (0) or clear mode (1).
// [R14] Eight-bit count register sets consecutive matching samples needed.
// [R15] Decrement mode steps down to zero; clear mode zeroes at once.
// [R16] Debounce counter advances once per sample period.
// [R17] Debounce count register resets to zero.
// [R18] Latch off: event and sign bits follow the latest debounced result.
// [R19] Config bits 7..5 and source bit 7 are don't-care for software.
module tad_detector
	import tad_pkg::*;
(
	input  wire logic         mclk,          // 40 MHz clock
	input  wire logic         rst,           // Async reset, active high
	input  wire tad_regreq_t  regReq,        // Register read/write strobe
	output var  logic [7:0]   rdData_r,      // Read data, one cycle later
	input  wire logic         irqEnable,     // Transient request enable
	input  wire logic         sampleValid,   // One pulse per sample period
	input  wire tad_sample_t  hpfSample,     // High-pass filtered sample
	input  wire tad_sample_t  rawSample,     // Unfiltered sample
	output var  logic         transIrq_r     // Transient request, level
);

	// Register storage
	logic [`TAD_CFG_W-1:0]   cfg_r;
	logic [`TAD_DW-1:0]      ths_r;
	logic [`TAD_DW-1:0]      countCfg_r;
	logic [`TAD_AXES-1:0]    evt_r;
	logic [`TAD_AXES-1:0]    pol_r;
	logic [`TAD_AXES-1:0]    evt_nxt;
	logic [`TAD_AXES-1:0]    pol_nxt;
	logic [`TAD_DW-1:0]      dbCnt_r [`TAD_AXES];
	logic [`TAD_DW-1:0]      dbCnt_nxt [`TAD_AXES];

	// Decode
	wire logic               wrCfg;
	wire logic               wrThs;
	wire logic               wrCnt;
	wire logic               srcRd;
	wire logic [7:0]         rdMux;
	wire logic [7:0]         srcVal;

	// Configuration fields
	wire logic               filterBypass;
	wire logic               flagLatchEnable;
	wire logic [`TAD_AXES-1:0] axisDetectEnable;
	wire logic [6:0]         thresholdValue;
	wire tad_dbmode_t        debounceModeSelect;

	// Detection per axis
	wire tad_sample_t        selSample;
	wire logic [`TAD_AXES-1:0] match;
	wire logic [`TAD_AXES-1:0] qual;
	wire logic [`TAD_AXES-1:0] hit;
	wire logic [`TAD_AXES-1:0] sign;
	wire logic               eventActive;
	wire logic               frozen;
	wire logic [`TAD_AXES-1:0] baseEvt;
	wire logic [`TAD_AXES-1:0] basePol;

	assign wrCfg = regReq.wr && (regReq.addr == `TAD_ADDR_CFG);
	assign wrThs = regReq.wr && (regReq.addr == `TAD_ADDR_THS);
	assign wrCnt = regReq.wr && (regReq.addr == `TAD_ADDR_CNT);
	assign srcRd = regReq.rd && (regReq.addr == `TAD_ADDR_SRC);

	assign filterBypass     = cfg_r[`TAD_CFG_BYP];
	assign flagLatchEnable  = cfg_r[`TAD_CFG_ELE];
	assign axisDetectEnable = cfg_r[`TAD_CFG_XEN +: `TAD_AXES];
	// [R12] Seven-bit threshold
	assign thresholdValue   = ths_r[`TAD_THS_MSB:0];
	// [R13] Debounce mode bit
	assign debounceModeSelect = tad_dbmode_t'(ths_r[`TAD_THS_MODE]);

	// [R1] Detector input select
	assign selSample = filterBypass ? rawSample : hpfSample;

	genvar i;
	generate
		for (i = 0; i < `TAD_AXES; i++) begin : g_axis
			wire logic [7:0] s;
			wire logic [7:0] mag;
			wire logic       atCount;
			wire logic       atZero;

			assign s       = selSample.axis[i];
			// Two's complement magnitude; -128 gives 128 unsigned
			assign mag     = s[7] ? (`TAD_ZERO8 - s) : s;
			// [R10] Strictly above threshold
			assign match[i] = mag > {1'b0, thresholdValue};
			assign sign[i]  = s[7];
			assign atCount  = (dbCnt_r[i] >= countCfg_r);
			assign atZero   = (dbCnt_r[i] == `TAD_ZERO8);

			// [R15] Step, hold or clear
			always_comb begin
				dbCnt_nxt[i] = dbCnt_r[i];
				if (match[i]) begin
					if (!atCount) begin
						dbCnt_nxt[i] = dbCnt_r[i] + `TAD_ONE8;
					end
				end else if (debounceModeSelect == TAD_DB_CLR) begin
					dbCnt_nxt[i] = `TAD_ZERO8;
				end else if (!atZero) begin
					dbCnt_nxt[i] = dbCnt_r[i] - `TAD_ONE8;
				end
			end

			// [R14] Counter at or past programmed count
			// A count lowered below a saturated counter must still qualify
			assign qual[i] = match[i] && (dbCnt_nxt[i] >= countCfg_r);
			// [R2] Axis enable gates the flag
			assign hit[i]  = qual[i] && axisDetectEnable[i] && sampleValid;

			// [R16] One step per sample
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					dbCnt_r[i] <= `TAD_ZERO8;
				end else if (sampleValid) begin
					dbCnt_r[i] <= dbCnt_nxt[i];
				end
			end

			// [R8] Event bits at odd positions
			assign srcVal[2*i+1] = evt_r[i];
			// [R9] Sign bits at even positions
			assign srcVal[2*i]   = pol_r[i];
		end
	endgenerate

	// [R7] Active when any axis flag is set
	assign eventActive = |evt_r;
	assign srcVal[`TAD_SRC_EA]  = eventActive;
	// [R19] Unused bit reads zero
	assign srcVal[`TAD_SRC_RSV] = 1'b0;

	// [R4] Read clears source bits
	assign baseEvt = srcRd ? '0 : evt_r;
	assign basePol = srcRd ? '0 : pol_r;

	// [R6] Freeze once active with latch on
	assign frozen = flagLatchEnable && eventActive && !srcRd;

	always_comb begin
		evt_nxt = baseEvt;
		pol_nxt = basePol;
		if (!flagLatchEnable) begin
			// [R18] Follow latest debounced result
			if (sampleValid) begin
				evt_nxt = hit;
				pol_nxt = hit & sign;
			end
		end else if (!frozen) begin
			// [R5] Set only, never clear before read
			// [R3] Latched until source read
			evt_nxt = baseEvt | hit;
			pol_nxt = (hit & sign) | (~hit & basePol);
		end
	end

	// [R11] Flags and request update
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			evt_r      <= '0;
			pol_r      <= '0;
			transIrq_r <= 1'b0;
		end else begin
			evt_r      <= evt_nxt;
			pol_r      <= pol_nxt;
			transIrq_r <= irqEnable && (|evt_nxt);
		end
	end

	// Configuration writes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_r <= `TAD_CFG_RST;
		end else if (wrCfg) begin
			cfg_r <= regReq.data[`TAD_CFG_W-1:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ths_r <= `TAD_THS_RST;
		end else if (wrThs) begin
			ths_r <= regReq.data;
		end
	end

	// [R17] Count register resets to zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			countCfg_r <= `TAD_CNT_RST;
		end else if (wrCnt) begin
			countCfg_r <= regReq.data;
		end
	end

	// Read data mux; unmapped addresses read zero
	assign rdMux =
		(regReq.addr == `TAD_ADDR_CFG) ? {3'h0, cfg_r} :
		(regReq.addr == `TAD_ADDR_SRC) ? srcVal :
		(regReq.addr == `TAD_ADDR_THS) ? ths_r :
		(regReq.addr == `TAD_ADDR_CNT) ? countCfg_r :
		`TAD_ZERO8;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData_r <= `TAD_ZERO8;
		end else if (regReq.rd) begin
			rdData_r <= rdMux;
		end
	end

endmodule : tad_detector
`default_nettype wire

/* File: rtl/tad_params.svh */
// Constants of the transient event detector: addresses, bit fields, resets.
// Assumes an 8-bit register address space reached through a plain register port.
`ifndef TAD_PARAMS_SVH
`define TAD_PARAMS_SVH

`define TAD_ADDR_CFG    8'h1D
`define TAD_ADDR_SRC    8'h1E
`define TAD_ADDR_THS    8'h1F
`define TAD_ADDR_CNT    8'h20

`define TAD_CFG_BYP     0
`define TAD_CFG_XEN     1
`define TAD_CFG_ELE     4
`define TAD_CFG_W       5
`define TAD_CFG_RST     5'h00

`define TAD_THS_MSB     6
`define TAD_THS_MODE    7
`define TAD_THS_RST     8'h00
`define TAD_CNT_RST     8'h00

`define TAD_SRC_EA      6
`define TAD_SRC_RSV     7

`define TAD_AXES        3
`define TAD_DW          8
`define TAD_ZERO8       8'h00
`define TAD_ONE8        8'h01

`endif

/* File: rtl/tad_pkg.sv */
// Types of the transient event detector: register request and axis samples.
// Assumes tad_params.svh is on the include path.
`include "tad_params.svh"

package tad_pkg;

	// One register access from the serial port front end
	typedef struct packed {
		logic                rd;
		logic                wr;
		logic [7:0]          addr;
		logic [7:0]          data;
	} tad_regreq_t;

	// Signed samples on the 8 g scale, index 0 is X, 1 is Y, 2 is Z
	typedef struct packed {
		logic [2:0][7:0]     axis;
	} tad_sample_t;

	typedef enum logic {
		TAD_DB_DEC = 1'b0,
		TAD_DB_CLR = 1'b1
	} tad_dbmode_t;

endpackage : tad_pkg

/* File: tb/tad_monitor.sv */
// Port checker of the transient detector.
// Assumes it is bound to every tad_detector.
`timescale 1ns/1ps
`default_nettype none
module tad_monitor
	import tad_pkg::*;
(
	input wire logic        mclk,        // Clock
	input wire logic        rst,         // Reset
	input wire tad_regreq_t regReq,      // Access
	input wire logic [7:0]  rdData_r,    // Read data
	input wire logic        irqEnable,   // Enable
	input wire logic        sampleValid, // Sample
	input wire logic        transIrq_r   // Request
);
	wire logic srcRd;
	assign srcRd = regReq.rd && regReq.addr == 8'h1E;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_irq_needs_en: assert property (transIrq_r |-> $past(irqEnable))
		else $error("request without enable");
	a_read_clears: assert property (srcRd && !sampleValid |=> !transIrq_r)
		else $error("request after read");
	a_idle_stays_low: assert property (!transIrq_r && !sampleValid && irqEnable
		&& $past(irqEnable) |=> !transIrq_r) else $error("request without sample");
	a_src_rsv_zero: assert property (srcRd |=> !rdData_r[7])
		else $error("source bit 7 set");
	a_active_is_or: assert property (srcRd |=> rdData_r[6] ==
		|{rdData_r[5], rdData_r[3], rdData_r[1]}) else $error("active flag wrong");
	a_sign_needs_evt: assert property (srcRd |=>
		(rdData_r & ~(rdData_r >> 1) & 8'h15) == 8'h00) else $error("sign alone");
	a_reread_empty: assert property (srcRd && !sampleValid ##1 !sampleValid
		##1 srcRd |=> rdData_r[6:0] == 7'h00) else $error("second read not empty");
	a_irq_tracks_ea: assert property (srcRd |=> $past(transIrq_r) ==
		(rdData_r[6] && $past(irqEnable, 2))) else $error("request not active flag");
endmodule : tad_monitor
bind tad_detector tad_monitor u_mon (.mclk(mclk), .rst(rst), .regReq(regReq),
	.rdData_r(rdData_r), .irqEnable(irqEnable), .sampleValid(sampleValid),
	.transIrq_r(transIrq_r));
`default_nettype wire

/* File: tb/tad_host.sv */
// Host model: register reads and writes on the strobe port.
// Assumes the detector samples requests at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tad_host
	import tad_pkg::*;
(
	input  wire logic       mclk,   // Clock
	output var tad_regreq_t req,    // Access
	input  wire logic [7:0] rdData  // Read data
);
	initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'hA5, data: 8'h5A};
	// Released address and data lines show the inverse; both strobes drop low
	task xfer(input logic r, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge mclk);
		req = '{rd: r, wr: !r, addr: a, data: d};
		@(negedge mclk);
		q = rdData;
		req = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
	endtask : xfer
endmodule : tad_host
`default_nettype wire

/* File: tb/tb_transient_accel_event_detector.sv */
// Self-checking bench of the transient detector.
// Assumes tad_host and the bound tad_monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_transient_accel_event_detector
	import tad_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        irqEnable = 1'b1;
	logic        sampleValid = 1'b0;
	tad_sample_t hpfSample = '0;
	tad_sample_t rawSample = '0;
	tad_regreq_t regReq;
	logic [7:0]  rdData_r;
	logic        transIrq_r;
	logic [7:0]  q;
	logic [7:0]  axExp [1:3] = '{8'h42, 8'h4C, 8'h70};
	int          fail_count = 0;
	int          n_tests = 0;
	always #12.5 mclk = ~mclk;
	tad_host u_host (.mclk(mclk), .req(regReq), .rdData(rdData_r));
	tad_detector u_dut (.mclk(mclk), .rst(rst), .regReq(regReq), .rdData_r(rdData_r),
		.irqEnable(irqEnable), .sampleValid(sampleValid), .hpfSample(hpfSample),
		.rawSample(rawSample), .transIrq_r(transIrq_r));
	task end_of_test();
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task rd(input logic [7:0] a, e);
		u_host.xfer(1'b1, a, 8'h00, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	task rs(input logic [7:0] e);
		rd(8'h1E, e);
	endtask : rs
	task wr(input logic [7:0] a, d);
		u_host.xfer(1'b0, a, d, q);
	endtask : wr
	// One sample pulse, Z Y X packed high to low
	task smp(input logic [23:0] h, r);
		@(negedge mclk);
		sampleValid = 1'b1;
		hpfSample = tad_sample_t'(h);
		rawSample = tad_sample_t'(r);
		@(negedge mclk);
		sampleValid = 1'b0;
	endtask : smp
	// Whole run is about 140 cycles
	initial begin
		#20us;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		for (int a = 8'h1D; a < 8'h22; a++) rd(8'(a), 8'h00);
		wr(8'h1D, 8'hFF);
		rd(8'h1D, 8'h1F);
		wr(8'h1E, 8'hFF);
		rs(8'h00);
		wr(8'h1D, 8'h02);
		wr(8'h1F, 8'h0A);
		wr(8'h20, 8'h02);
		smp(24'h00000A, 24'h000000);
		smp(24'h00000B, 24'h000000);
		rs(8'h00);
		smp(24'h0000EC, 24'h000000);
		chk("irq", 8'h01, {7'h00, transIrq_r});
		rs(8'h43);
		rs(8'h00);
		smp(24'h000014, 24'h000000);
		smp(24'h000000, 24'h000000);
		rs(8'h00);
		smp(24'h000014, 24'h000000);
		rs(8'h42);
		wr(8'h1F, 8'h8A);
		rd(8'h1F, 8'h8A);
		smp(24'h000000, 24'h000000);
		smp(24'h000014, 24'h000000);
		rs(8'h00);
		smp(24'h000014, 24'h000000);
		rs(8'h42);
		wr(8'h20, 8'h00);
		wr(8'h1D, 8'h03);
		smp(24'h000000, 24'h0000EC);
		rs(8'h43);
		wr(8'h1D, 8'h02);
		smp(24'h000000, 24'h0000EC);
		rs(8'h00);
		irqEnable = 1'b0;
		for (int i = 1; i < 4; i++) begin
			wr(8'h1D, 8'(1 << i));
			smp(24'h80EC14, 24'h000000);
			rs(axExp[i]);
		end
		chk("irq", 8'h00, {7'h00, transIrq_r});
		wr(8'h1D, 8'h0E);
		smp(24'h80EC14, 24'h000000);
		rs(8'h7E);
		irqEnable = 1'b1;
		wr(8'h1F, 8'hFF);
		wr(8'h1D, 8'h02);
		smp(24'h00007F, 24'h000000);
		rs(8'h00);
		smp(24'h000080, 24'h000000);
		rs(8'h43);
		wr(8'h1F, 8'h0A);
		wr(8'h1D, 8'h12);
		smp(24'h0000EC, 24'h000000);
		smp(24'h000014, 24'h000000);
		smp(24'h000000, 24'h000000);
		rs(8'h43);
		rs(8'h00);
		wr(8'h1D, 8'h1E);
		smp(24'h80EC14, 24'h000000);
		rs(8'h7E);
		end_of_test();
	end
endmodule : tb_transient_accel_event_detector
`default_nettype wire
